// ### rtl/always_on_timekeeper.sv
/*
 * Always-on timekeeper: 32.768 kHz source selection with crystal check,
 * prescaler and seconds counter, periodic and alarm events, wake and clock
 * outputs, crystal pins as GPIO, Avalon-MM register slave.
 * Assumes oscillator levels and pins are synchronous to CLK_SYS and that
 * PWR_DOWN comes from the power controller.
 */
`timescale 1ns/1ps
`default_nettype none
`include "timekeeper_defines.svh"

module always_on_timekeeper
    import timekeeper_pkg::*;
#(
    parameter int GOOD_EDGES = `OSC_GOOD_EDGES
) (
    // Clock, reset, enable
    input  wire logic        CLK_SYS,
    input  wire logic        SYS_RST,
    input  wire logic        CE,
    // Power mode
    input  wire logic        PWR_DOWN,
    // Avalon-MM slave
    input  wire logic [4:0]  ADDRESS,
    input  wire logic        READ,
    input  wire logic        WRITE,
    input  wire logic [31:0] WRITEDATA,
    input  wire logic [3:0]  BYTEENABLE,
    output logic [31:0]      READDATA,
    output logic             WAITREQUEST,
    output logic             IRQ,
    // Oscillators
    input  wire logic        FREE_RUNNING_OSC,
    output logic             FRO_ENABLE,
    output logic             CRYSTAL_ENABLE,
    output logic             SYS_CLK32K,
    // Crystal pins
    input  wire logic        OSC32_IN_I,
    output logic             OSC32_IN_O,
    output logic             OSC32_IN_OE,
    input  wire logic        OSC32_OUT_I,
    output logic             OSC32_OUT_O,
    output logic             OSC32_OUT_OE,
    // Tamper pins and outputs
    input  wire logic        TAMPER_IN_0_I,
    output logic             TAMPER_IN_0_O,
    output logic             TAMPER_IN_0_OE,
    input  wire logic        TAMPER_IN_1_I,
    output logic             TAMPER_IN_1_O,
    output logic             TAMPER_IN_1_OE,
    input  wire logic        TAMPER_IN_2,
    output logic             WAKE_N,
    output logic             TIMEKEEPER_CLOCK_OUT
);

    // Byte-enable merge of a write into a register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~m) | (wd & m);
    endfunction : merge

    // Prescaler bits below the periodic rate boundary
    function automatic logic [`PRE_W-1:0] rate_mask(input logic [2:0] r);
        return 15'h7FFF >> r;
    endfunction : rate_mask

    ctrl_t             ctrl;          // Control register
    logic [2:0]        rate;          // Periodic rate, 2^rate Hz
    logic [31:0]       seconds;       // Time counter
    logic [31:0]       alarm;         // Alarm compare value
    evt_t              status;        // Sticky events
    evt_t              mask;          // Interrupt mask
    logic [3:0]        gpio;          // {oe_out, oe_in, val_out, val_in}
    src_state_t        src;           // Current source state
    logic [`PRE_W-1:0] prescaler;     // 32k tick counter
    logic              fro_prev;      // Previous oscillator levels
    logic              xtal_prev;
    logic [2:0]        tamper_prev;   // Previous tamper levels
    logic              xtal_valid;    // Crystal checker verdict
    logic              xtal_rise;     // Crystal rising edge
    logic              fro_rise;      // Oscillator rising edge
    logic              tick;          // One 32k period elapsed
    logic              wrap;          // Prescaler rolls over
    logic              on_xtal;       // Counting from crystal
    logic              clk32;         // Selected 32k level
    evt_t              evt;           // Events this cycle
    logic              wr_fire;       // Write takes effect
    logic              rd_fire;       // Read completes
    logic [31:0]       rd_mux;        // Read data selection
    logic [31:0]       ctrl_wide;     // Control as a bus word
    logic [31:0]       ctrl_merged;   // Control word after the byte merge
    ctrl_t             next_ctrl;     // Control after a write

    // Bus strobes; nothing lands while isolated
    assign wr_fire = WRITE && !WAITREQUEST && !PWR_DOWN;
    assign rd_fire = READ && !WAITREQUEST && !PWR_DOWN;

    // Edge detection on the synchronous oscillator levels
    assign xtal_rise = OSC32_IN_I && !xtal_prev;
    assign fro_rise  = FREE_RUNNING_OSC && !fro_prev && ctrl.fro_en;
    assign on_xtal   = (src == SRC_XTAL);
    assign tick      = on_xtal ? xtal_rise : fro_rise;
    assign clk32     = on_xtal ? OSC32_IN_I : (FREE_RUNNING_OSC && ctrl.fro_en);
    assign wrap      = tick && ctrl.count_en && (prescaler == 15'h7FFF);

    // Event sources of the counter and tamper pins
    always_comb begin
        evt          = '0;
        evt.periodic = tick && ctrl.count_en &&
                       ((prescaler & rate_mask(rate)) == rate_mask(rate));
        evt.alarm    = wrap && ((seconds + 32'h0000_0001) == alarm);
        // Pin enables lag the control bit one cycle; both mask our own drive
        evt.tamper0  = TAMPER_IN_0_I && !tamper_prev[0] && !ctrl.wake_to_t0 && !TAMPER_IN_0_OE;
        evt.tamper1  = TAMPER_IN_1_I && !tamper_prev[1] && !ctrl.clkout_to_t1 && !TAMPER_IN_1_OE;
        evt.tamper2  = TAMPER_IN_2 && !tamper_prev[2];
    end

    // Write path of the control word
    assign ctrl_wide = {{(32 - `CTRL_W){1'b0}}, ctrl};
    assign ctrl_merged = merge(ctrl_wide, WRITEDATA, BYTEENABLE);
    assign next_ctrl   = ctrl_t'(ctrl_merged[`CTRL_W-1:0]);

    // Crystal stability checker, idle while the pin is a GPIO
    crystal_checker #(
        .GOOD_EDGES (GOOD_EDGES)
    ) u_check (
        .clk       (CLK_SYS),
        .rst       (SYS_RST),
        .ce        (CE),
        .enable    (ctrl.osc_en && !ctrl.gpio_in_mode),
        .edge_seen (xtal_rise),
        .valid     (xtal_valid)
    );

    // Level history for edge detection
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            fro_prev    <= 1'b0;
            xtal_prev   <= 1'b0;
            tamper_prev <= 3'h0;
        end else if (CE) begin
            fro_prev    <= FREE_RUNNING_OSC;
            xtal_prev   <= OSC32_IN_I;
            tamper_prev <= {TAMPER_IN_2, TAMPER_IN_1_I, TAMPER_IN_0_I};
        end
    end

    // Control register: oscillator on, crystal off, counting on
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            ctrl <= ctrl_t'(`CTRL_RST);
        end else if (CE && wr_fire && ADDRESS == `OFS_CTRL) begin
            ctrl <= next_ctrl;
        end
    end

    // Periodic rate, 1 Hz after reset
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            rate <= `RATE_RST;
        end else if (CE && wr_fire && ADDRESS == `OFS_RATE && BYTEENABLE[0]) begin
            rate <= WRITEDATA[2:0];
        end
    end

    // Alarm and mask registers
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            alarm <= 32'h0000_0000;
            mask  <= '0;
        end else if (CE && wr_fire) begin
            if (ADDRESS == `OFS_ALARM) begin
                alarm <= merge(alarm, WRITEDATA, BYTEENABLE);
            end
            if (ADDRESS == `OFS_MASK && BYTEENABLE[0]) begin
                mask <= evt_t'(WRITEDATA[`EVT_W-1:0]);
            end
        end
    end

    // Source switch: crystal only once checked, back on disable
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            src <= SRC_FRO;
        end else if (CE) begin
            unique case (src)
                SRC_FRO: begin
                    if (ctrl.osc_en && !ctrl.gpio_in_mode) begin
                        src <= SRC_CHECK;
                    end
                end
                SRC_CHECK: begin
                    if (!ctrl.osc_en || ctrl.gpio_in_mode) begin
                        src <= SRC_FRO;
                    end else if (xtal_valid && xtal_rise) begin
                        src <= SRC_XTAL;
                    end
                end
                SRC_XTAL: begin
                    // A failing crystal also drops back to keep time
                    if (!ctrl.osc_en || ctrl.gpio_in_mode || !xtal_valid) begin
                        src <= SRC_FRO;
                    end
                end
                default: begin
                    src <= SRC_FRO;
                end
            endcase
        end
    end

    // Prescaler and seconds; runs regardless of power-down
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            prescaler <= 15'h0000;
            seconds   <= 32'h0000_0000;
        end else if (CE) begin
            if (tick && ctrl.count_en) begin
                prescaler <= prescaler + 15'h0001;
            end
            if (wr_fire && ADDRESS == `OFS_SECONDS) begin
                seconds <= merge(seconds, WRITEDATA, BYTEENABLE);
            end else if (wrap) begin
                seconds <= seconds + 32'h0000_0001;
            end
        end
    end

    // Sticky status; a new event beats the read clear
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            status <= '0;
        end else if (CE) begin
            if (rd_fire && ADDRESS == `OFS_STATUS) begin
                // Only bits the reader saw are cleared
                status <= (status & ~evt_t'(READDATA[`EVT_W-1:0])) | evt;
            end else begin
                status <= status | evt;
            end
        end
    end

    // GPIO use of the crystal pins
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            gpio <= `GPIO_RST;
        end else if (CE && wr_fire && ADDRESS == `OFS_GPIO && BYTEENABLE[0]) begin
            gpio <= WRITEDATA[3:0];
        end
    end

    // Read multiplexer
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (ADDRESS)
            `OFS_CTRL:    rd_mux = ctrl_wide;
            `OFS_RATE:    rd_mux = {29'h0000_0000, rate};
            `OFS_SECONDS: rd_mux = seconds;
            `OFS_ALARM:   rd_mux = alarm;
            `OFS_STATUS:  rd_mux = {27'h000_0000, status};
            `OFS_MASK:    rd_mux = {27'h000_0000, mask};
            `OFS_STATE:   rd_mux = {26'h000_0000, OSC32_OUT_I, OSC32_IN_I,
                                    PWR_DOWN, xtal_valid, src};
            `OFS_GPIO:    rd_mux = {28'h000_0000, gpio};
            default:      rd_mux = 32'h0000_0000;                              // Unmapped reads zero
        endcase
    end

    // Avalon handshake: one wait state, then the answer
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            WAITREQUEST <= 1'b1;
            READDATA    <= 32'h0000_0000;
        end else if (CE) begin
            if ((READ || WRITE) && WAITREQUEST) begin
                WAITREQUEST <= 1'b0;
                // Isolated block answers with zero and ignores writes
                READDATA    <= (READ && !PWR_DOWN) ? rd_mux : 32'h0000_0000;
            end else begin
                WAITREQUEST <= 1'b1;
            end
        end
    end

    // Interrupt and wake; both work while powered down
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            IRQ    <= 1'b0;
            WAKE_N <= 1'b1;
        end else if (CE) begin
            IRQ    <= |(status & mask);
            WAKE_N <= !(ctrl.wake_en && |(status & mask));
        end
    end

    // Clock outputs; chip-wide 32k is cut when isolated
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            TIMEKEEPER_CLOCK_OUT <= 1'b0;
            SYS_CLK32K           <= 1'b0;
        end else if (CE) begin
            TIMEKEEPER_CLOCK_OUT <= ctrl.clkout_en &&
                (ctrl.clkout_sel ? clk32 : prescaler[`PRE_MSB - {1'b0, rate}]);
            SYS_CLK32K           <= ctrl.sysclk_en && !PWR_DOWN && clk32;
        end
    end

    // Oscillator enables and pin drivers
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            FRO_ENABLE     <= 1'b1;
            CRYSTAL_ENABLE <= 1'b0;
            OSC32_IN_O     <= 1'b0;
            OSC32_IN_OE    <= 1'b0;
            OSC32_OUT_O    <= 1'b0;
            OSC32_OUT_OE   <= 1'b0;
            TAMPER_IN_0_O  <= 1'b1;
            TAMPER_IN_0_OE <= 1'b0;
            TAMPER_IN_1_O  <= 1'b0;
            TAMPER_IN_1_OE <= 1'b0;
        end else if (CE) begin
            FRO_ENABLE     <= ctrl.fro_en;
            CRYSTAL_ENABLE <= ctrl.osc_en && !ctrl.gpio_in_mode;
            OSC32_IN_O     <= gpio[0];
            OSC32_IN_OE    <= ctrl.gpio_in_mode && gpio[2];
            OSC32_OUT_O    <= gpio[1];
            OSC32_OUT_OE   <= ctrl.gpio_out_mode && gpio[3];
            TAMPER_IN_0_O  <= !(ctrl.wake_en && |(status & mask));
            TAMPER_IN_0_OE <= ctrl.wake_to_t0;
            TAMPER_IN_1_O  <= ctrl.clkout_en &&
                (ctrl.clkout_sel ? clk32 : prescaler[`PRE_MSB - {1'b0, rate}]);
            TAMPER_IN_1_OE <= ctrl.clkout_to_t1;
        end
    end

endmodule : always_on_timekeeper
`default_nettype wire

// ### rtl/crystal_checker.sv
/*
 * Crystal stability checker: declares the crystal valid after a run of edges
 * whose spacing lies inside the tolerance window.
 * Assumes a one-cycle rising-edge pulse of the crystal level on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "timekeeper_defines.svh"

module crystal_checker
    import timekeeper_pkg::*;
#(
    parameter int GOOD_EDGES = `OSC_GOOD_EDGES
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic enable,
    input  wire logic edge_seen,
    output var  logic valid
);

    localparam logic [9:0]  GAP_MIN_C = 10'(`GAP_MIN);   // Shortest legal half-cycle-free period
    localparam logic [9:0]  GAP_MAX_C = 10'(`GAP_MAX);   // Longest legal period
    localparam logic [15:0] GOOD_C    = 16'(GOOD_EDGES); // Run length to validate

    logic [9:0]  gap;    // Cycles since last edge
    logic [15:0] run;    // Consecutive good periods

    // Spacing counter, saturates so a dead crystal is seen
    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            gap <= 10'h000;
        end else if (ce) begin
            if (edge_seen) begin
                gap <= 10'h000;
            end else if (gap != 10'h3FF) begin
                gap <= gap + 10'h001;
            end
        end
    end

    // Run of good periods; any bad gap or stall restarts it
    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            run   <= 16'h0000;
            valid <= 1'b0;
        end else if (ce) begin
            if ((edge_seen && (gap < GAP_MIN_C)) || (gap > GAP_MAX_C)) begin
                run   <= 16'h0000;       // Glitch or lost clock
                valid <= 1'b0;
            end else if (edge_seen) begin
                if (run >= GOOD_C) begin
                    valid <= 1'b1;
                end else begin
                    run <= run + 16'h0001;
                end
            end
        end
    end

endmodule : crystal_checker
`default_nettype wire

// ### rtl/timekeeper_defines.svh
/*
 * Offsets, field positions, reset values and timing counts of the always-on timekeeper.
 * Assumes a 10 MHz system clock and 32.768 kHz oscillator levels sampled on it.
 */
// Functional notes
// - Time counter advances from 32.768 kHz clock
// - Source selectable: crystal or free-running oscillator
// - Switch to crystal only after it validates
// - Crystal disabled falls back to free-running oscillator
// - Free-running oscillator on after reset, disableable
// - Crystal off after reset until software enables
// - Keeps working in low power, can wake
// - Powered-up: registers accessible, 32k clock supplied
// - Power-down: isolated, keeps counting, keeps state
// - Power-down refuses software register access
// - Counter raises several interrupts and events
// - Periodic rate resets 1 Hz, up to 128
// - Active-low wake output, routable to tamper 0
// - Clock output routable to tamper 1
// - Crystal pins usable as general-purpose I/O
`ifndef TIMEKEEPER_DEFINES_SVH
`define TIMEKEEPER_DEFINES_SVH

// Byte offsets on the register bus
`define OFS_CTRL     5'h00
`define OFS_RATE     5'h04
`define OFS_SECONDS  5'h08
`define OFS_ALARM    5'h0C
`define OFS_STATUS   5'h10
`define OFS_MASK     5'h14
`define OFS_STATE    5'h18
`define OFS_GPIO     5'h1C

// Reset values
`define CTRL_RST     11'h005
`define RATE_RST     3'h0
`define GPIO_RST     4'h0

// Field widths and positions
`define CTRL_W       11
`define EVT_W        5
`define EVT_PERIODIC 0
`define EVT_ALARM    1
`define EVT_TAMPER0  2
`define PRE_W        15
`define PRE_MSB      4'hE

// Timing
`define SYS_HZ       10000000
`define OSC_HZ       32768
`define OSC_TOL_PCT  25
`define OSC_GOOD_EDGES 1024
`define GAP_MIN ((`SYS_HZ * (100 - `OSC_TOL_PCT) + `OSC_HZ * 100 - 1) / (`OSC_HZ * 100))
`define GAP_MAX ((`SYS_HZ * (100 + `OSC_TOL_PCT)) / (`OSC_HZ * 100))

`endif

// ### rtl/timekeeper_pkg.sv
/*
 * Types shared by the timekeeper top and its crystal checker.
 * Assumes the defines header for all numeric constants.
 */
package timekeeper_pkg;

    // Software control word
    typedef struct packed {
        logic gpio_out_mode;  // osc32_out pin is a GPIO
        logic gpio_in_mode;   // osc32_in pin is a GPIO
        logic clkout_to_t1;   // Clock output onto tamper pin 1
        logic wake_to_t0;     // Wake output onto tamper pin 0
        logic wake_en;        // Wake output follows interrupt
        logic clkout_sel;     // 1: raw 32k clock, 0: prescaler wave
        logic clkout_en;      // Clock output enable
        logic sysclk_en;      // 32k clock to the rest of the chip
        logic count_en;       // Time counter enable
        logic osc_en;         // Crystal oscillator enable
        logic fro_en;         // Free-running oscillator enable
    } ctrl_t;

    // Event vector, same layout in status and mask
    typedef struct packed {
        logic tamper2;
        logic tamper1;
        logic tamper0;
        logic alarm;
        logic periodic;
    } evt_t;

    // Timekeeping source selection
    typedef enum logic [1:0] {
        SRC_FRO   = 2'b00,
        SRC_CHECK = 2'b01,
        SRC_XTAL  = 2'b10
    } src_state_t;

endpackage : timekeeper_pkg

// ### verif/osc_model.sv
/* Partner oscillators: a fast free-running level and a 300-cycle crystal.
   Assumes the 10 MHz bench clock. */
`timescale 1ns/1ps
`default_nettype none
module osc_model (
    // Clock and enables
    input  wire logic clk,
    input  wire logic fro_on,
    input  wire logic xtal_on,
    // Oscillator levels
    output wire logic free_running_osc,
    output wire logic xtal
);
    logic [1:0] c = 2'h0;  // Free-running phase
    logic [7:0] d = 8'h00; // Crystal half-period count
    logic       x = 1'b0;  // Crystal level
    // Both stand still at 0 while disabled; the free one is shortened to keep runs brief
    always_ff @(posedge clk) begin
        c <= c + 2'h1;
        d <= (d == 8'h95 || !xtal_on) ? 8'h00 : d + 8'h01;
        if (!xtal_on) x <= 1'b0;
        else if (d == 8'h95) x <= ~x;
    end
    assign free_running_osc  = fro_on & c[1];
    assign xtal = x;             // Period 300, inside the stability window
endmodule : osc_model
`default_nettype wire

// ### verif/tb_top.sv
/* Bench for the timekeeper: register bus tasks and directed sequences.
   Assumes the partner oscillator model and a 10 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
`include "timekeeper_defines.svh"
module tb_top;
    import timekeeper_pkg::*;
    logic        CLK_SYS = 1'b0, SYS_RST = 1'b1, PWR_DOWN = 1'b0, READ = 1'b0, WRITE = 1'b0;
    logic        TAMPER_IN_2 = 1'b0, xtal;
    logic [4:0]  ADDRESS = 5'h00;
    logic [31:0] WRITEDATA = 32'h0, READDATA, rd;
    logic WAITREQUEST, IRQ, FRO_ENABLE, CRYSTAL_ENABLE, SYS_CLK32K, WAKE_N, TIMEKEEPER_CLOCK_OUT;
    logic FREE_RUNNING_OSC, OSC32_IN_O, OSC32_IN_OE, OSC32_OUT_O, OSC32_OUT_OE;
    logic TAMPER_IN_0_O, TAMPER_IN_0_OE, TAMPER_IN_1_O, TAMPER_IN_1_OE;
    wire logic       CE = 1'b1;
    wire logic [3:0] BYTEENABLE = 4'hF;
    // Pin levels from both drivers
    wire logic OSC32_IN_I    = OSC32_IN_OE ? OSC32_IN_O : xtal;
    wire logic OSC32_OUT_I   = OSC32_OUT_OE ? OSC32_OUT_O : 1'b0;
    wire logic TAMPER_IN_0_I = TAMPER_IN_0_OE ? TAMPER_IN_0_O : 1'b0;
    wire logic TAMPER_IN_1_I = TAMPER_IN_1_OE ? TAMPER_IN_1_O : 1'b0;
    int error_cnt = 0, checks = 0, cyc = 0, n, m;
    always_on_timekeeper #(.GOOD_EDGES(4)) dut (.*);
    osc_model osc (.clk(CLK_SYS), .fro_on(FRO_ENABLE), .xtal_on(CRYSTAL_ENABLE),
                   .free_running_osc(FREE_RUNNING_OSC), .xtal(xtal));
    always #50 CLK_SYS = ~CLK_SYS;
    task automatic report_and_stop();
        if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    // Cut a hang short
    always @(posedge CLK_SYS) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: got %h exp %h", $time, g, e);
        end
    endtask : cmp
    // One bus access; held until waitrequest is seen low
    task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
        READ      <= ~w;
        WRITE     <= w;
        ADDRESS   <= a;
        WRITEDATA <= d;
        do @(posedge CLK_SYS); while (WAITREQUEST !== 1'b0);
        rd = READDATA;
        READ  <= 1'b0;
        WRITE <= 1'b0;
        @(posedge CLK_SYS);
    endtask : acc
    initial begin
        repeat (16) @(posedge CLK_SYS);
        SYS_RST <= 1'b0;
        @(posedge CLK_SYS);
        cmp(32'(FRO_ENABLE), 32'h1);
        cmp(32'(CRYSTAL_ENABLE), 32'h0);
        acc(1'b0, `OFS_CTRL, 32'h0);
        cmp(rd, 32'h005);
        acc(1'b0, `OFS_RATE, 32'h0);
        cmp(rd, 32'h0);
        acc(1'b1, `OFS_SECONDS, 32'h1234_5678);
        acc(1'b0, `OFS_SECONDS, 32'h0);
        cmp(rd, 32'h1234_5678);
        acc(1'b1, `OFS_ALARM, 32'hA5C3_0F96);
        acc(1'b0, `OFS_ALARM, 32'h0);
        cmp(rd, 32'hA5C3_0F96);
        // Fastest periodic rate, wake and clock outputs on
        acc(1'b1, `OFS_RATE, 32'h7);
        acc(1'b1, `OFS_MASK, 32'h1);
        acc(1'b1, `OFS_CTRL, 32'h1FD);
        for (n = 0; n < 3000 && IRQ !== 1'b1; n++) @(posedge CLK_SYS);
        cmp(32'(IRQ), 32'h1);
        cmp(32'(WAKE_N), 32'h0);
        acc(1'b0, `OFS_STATUS, 32'h0);
        cmp(rd & 32'h1, 32'h1);
        n = 0;
        m = 0;
        repeat (40) begin
            @(posedge CLK_SYS);
            if (SYS_CLK32K === 1'b1) n++;
            if (TIMEKEEPER_CLOCK_OUT === 1'b1 && TAMPER_IN_1_O === 1'b1 && TAMPER_IN_1_OE === 1'b1) m++;
        end
        cmp(32'(n > 0 && n < 40), 32'h1);
        cmp(32'(m > 0 && m < 40), 32'h1);
        // Isolated: write ignored, read zero, counting goes on
        PWR_DOWN <= 1'b1;
        acc(1'b1, `OFS_CTRL, 32'h0);
        acc(1'b0, `OFS_CTRL, 32'h0);
        cmp(rd, 32'h0);
        repeat (1100) @(posedge CLK_SYS);
        PWR_DOWN <= 1'b0;
        acc(1'b0, `OFS_CTRL, 32'h0);
        cmp(rd, 32'h1FD);
        acc(1'b0, `OFS_STATUS, 32'h0);
        cmp(rd & 32'h1, 32'h1);
        TAMPER_IN_2 <= 1'b1;
        repeat (4) @(posedge CLK_SYS);
        acc(1'b0, `OFS_STATUS, 32'h0);
        cmp(rd & 32'h10, 32'h10);
        TAMPER_IN_2 <= 1'b0;
        // Crystal start, checked switch, fallback
        acc(1'b1, `OFS_CTRL, 32'h007);
        @(posedge CLK_SYS);
        cmp(32'(CRYSTAL_ENABLE), 32'h1);
        acc(1'b0, `OFS_STATE, 32'h0);
        cmp(32'(rd[1:0]), 32'(SRC_CHECK));
        for (n = 0; n < 1500 && rd[1:0] !== SRC_XTAL; n++) acc(1'b0, `OFS_STATE, 32'h0);
        cmp(32'(rd[1:0]), 32'(SRC_XTAL));
        acc(1'b1, `OFS_CTRL, 32'h005);
        acc(1'b0, `OFS_STATE, 32'h0);
        cmp(32'(rd[1:0]), 32'(SRC_FRO));
        // Crystal pins as general-purpose outputs
        acc(1'b1, `OFS_CTRL, 32'h605);
        acc(1'b1, `OFS_GPIO, 32'hE);
        @(posedge CLK_SYS);
        cmp(32'({OSC32_OUT_OE, OSC32_IN_OE, OSC32_OUT_O, CRYSTAL_ENABLE}), 32'hE);
        cmp(32'(OSC32_IN_O), 32'h0);
        acc(1'b0, `OFS_STATE, 32'h0);
        cmp(rd & 32'h3F, 32'h20);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire

// ### verif/timekeeper_asserts.sv
/* Checker on the timekeeper top ports: bus handshake, power-down refusal, wake and reset levels.
   Assumes CE stays high and a single clock domain. */
`timescale 1ns/1ps
`default_nettype none
module timekeeper_asserts #(
    parameter int GOOD_EDGES = 1024
) (
    // Clock, reset, power
    input wire logic        CLK_SYS,
    input wire logic        SYS_RST,
    input wire logic        PWR_DOWN,
    // Register bus
    input wire logic        READ,
    input wire logic        WRITE,
    input wire logic [31:0] READDATA,
    input wire logic        WAITREQUEST,
    // Outputs watched
    input wire logic        IRQ,
    input wire logic        FRO_ENABLE,
    input wire logic        CRYSTAL_ENABLE,
    input wire logic        SYS_CLK32K,
    input wire logic        TAMPER_IN_0_O,
    input wire logic        TAMPER_IN_0_OE,
    input wire logic        WAKE_N
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    // A taken request is answered after one wait state
    wait_one_a: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
        else $error("Bus answer late");
    answer_pulse_a: assert property (!WAITREQUEST |=> WAITREQUEST)
        else $error("Answer longer than one cycle");
    // No answer without a pending request
    no_spurious_a: assert property ($fell(WAITREQUEST) |-> $past(READ || WRITE))
        else $error("Answer without request");
    // Isolation: reads give zero while powered down
    pd_read_a: assert property (READ && WAITREQUEST && PWR_DOWN ##1 PWR_DOWN
        |-> !WAITREQUEST && READDATA == 32'h0)
        else $error("Read not refused in power-down");
    pd_clock_a: assert property (PWR_DOWN |=> !SYS_CLK32K)
        else $error("32k clock leaks in power-down");
    // Wake low only with an interrupt pending
    wake_irq_a: assert property (!WAKE_N |-> IRQ)
        else $error("Wake without interrupt");
    wake_pin_a: assert property (TAMPER_IN_0_OE |-> TAMPER_IN_0_O == WAKE_N)
        else $error("Tamper 0 not carrying wake");
    // Reset leaves the free-running source on, crystal off
    reset_out_a: assert property (disable iff (1'b0) SYS_RST |=> FRO_ENABLE && !CRYSTAL_ENABLE
        && WAKE_N && WAITREQUEST && !IRQ)
        else $error("Wrong levels after reset");
    cover property ($rose(IRQ));
    cover property (!WAKE_N && TAMPER_IN_0_OE);
    cover property (PWR_DOWN && READ && !WAITREQUEST);
endmodule : timekeeper_asserts
bind always_on_timekeeper timekeeper_asserts #(.GOOD_EDGES(GOOD_EDGES)) chk (.*);
`default_nettype wire
